// File: qst_status.sv
// Questionable status for the calibration and test-link subgroups.
// Assumes status pins are asynchronous and the command port is on clk.
`timescale 1ns/10ps
module qst_status
    import qst_pkg::*;
#(
    parameter int unsigned NO_CLK_CYCLES = QST_NO_CLK_CYCLES
)
(
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          reset_cmd,
    input  wire qst_sync_src_t sync_src,
    input  wire logic          test_clk_pin,
    input  wire logic          test_data_pin,
    input  wire logic          prbs_unsync,
    input  wire logic          demod_unlock,
    input  wire logic          downconv_unlock,
    input  wire logic          demod_amplitude_range_flag,
    input  wire logic          bch_sync_ok,
    input  wire logic          tch_sync_ok,
    input  wire logic          pdch_sync_ok,
    input  wire logic          midamble_seen,
    input  wire logic          iq_cal_fail,
    input  wire logic          dc_mod_zero_cal_fail,
    input  wire logic          reg_valid,
    input  wire logic          reg_write,
    input  wire qst_sel_t      reg_sel,
    input  wire logic [15:0]   reg_wdata,
    output logic      [15:0]   reg_rdata,
    output logic               reg_ack,
    output logic               cal_summary,
    output logic               test_summary
);

    // ==========================================================
    // Pin synchronisers
    logic [QST_IN_W-1:0] pin_raw;
    logic [QST_IN_W-1:0] pin_meta;
    logic [QST_IN_W-1:0] pin_sync;
    logic [QST_IN_W-1:0] pin_last;

    assign pin_raw = {dc_mod_zero_cal_fail, iq_cal_fail, midamble_seen, pdch_sync_ok,
                      tch_sync_ok, bch_sync_ok, demod_amplitude_range_flag,
                      downconv_unlock, demod_unlock, prbs_unsync, test_data_pin,
                      test_clk_pin};

    // Second stage feeds a history stage for edge detection
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_meta <= '0;
            pin_sync <= '0;
            pin_last <= '0;
        end else begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
            pin_last <= pin_sync;
        end
    end

    logic tclk_rise;
    logic tdata_change;
    logic sel_sync_ok;
    logic sel_sync_ok_last;

    assign tclk_rise    = qst_rise(pin_sync[QST_IN_TCLK], pin_last[QST_IN_TCLK]);
    assign tdata_change = pin_sync[QST_IN_TDATA] ^ pin_last[QST_IN_TDATA];

    // Selected channel sync status; an unused code behaves as BCH
    always_comb begin
        unique case (sync_src)
            QST_SRC_TCH: begin
                sel_sync_ok      = pin_sync[QST_IN_TCH];
                sel_sync_ok_last = pin_last[QST_IN_TCH];
            end
            QST_SRC_PDCH: begin
                sel_sync_ok      = pin_sync[QST_IN_PDCH];
                sel_sync_ok_last = pin_last[QST_IN_PDCH];
            end
            default: begin
                sel_sync_ok      = pin_sync[QST_IN_BCH];
                sel_sync_ok_last = pin_last[QST_IN_BCH];
            end
        endcase
    end

    // ==========================================================
    // Test clock and data activity monitors
    logic [QST_NO_CLK_CNT_W-1:0]  clk_gap;
    logic [QST_NO_CLK_CNT_W-1:0]  next_clk_gap;
    logic [QST_NO_DATA_CNT_W-1:0] quiet_edges;
    logic [QST_NO_DATA_CNT_W-1:0] next_quiet_edges;
    logic                         no_clk;
    logic                         no_data;

    localparam logic [QST_NO_CLK_CNT_W-1:0]  GAP_LIMIT   = QST_NO_CLK_CNT_W'(NO_CLK_CYCLES);
    localparam logic [QST_NO_DATA_CNT_W-1:0] QUIET_LIMIT = QST_NO_DATA_CNT_W'(QST_NO_DATA_EDGES);

    // Counters saturate so a stopped clock never wraps back to idle
    always_comb begin
        if (tclk_rise) begin
            next_clk_gap = '0;
        end else if (clk_gap > GAP_LIMIT) begin
            next_clk_gap = clk_gap;
        end else begin
            next_clk_gap = clk_gap + 1'b1;
        end
        if (tdata_change) begin
            next_quiet_edges = '0;
        end else if (tclk_rise && quiet_edges < QUIET_LIMIT) begin
            next_quiet_edges = quiet_edges + 1'b1;
        end else begin
            next_quiet_edges = quiet_edges;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clk_gap     <= '0;
            quiet_edges <= '0;
        end else begin
            clk_gap     <= next_clk_gap;
            quiet_edges <= next_quiet_edges;
        end
    end

    assign no_clk  = clk_gap > GAP_LIMIT;
    assign no_data = quiet_edges >= QUIET_LIMIT;

    // ==========================================================
    // Reset-command masking of live flags
    // A reset command hides a flag until its source drops, so a still
    // asserted source does not reappear the very next cycle.
    logic [2:0] raw_flag;
    logic [2:0] hold_zero;
    logic [2:0] next_hold_zero;
    logic [2:0] live_flag;

    assign raw_flag = {~sel_sync_ok, pin_sync[QST_IN_AMP], pin_sync[QST_IN_PRBS]};

    always_comb begin
        next_hold_zero = reset_cmd ? 3'b111 : (hold_zero & raw_flag);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hold_zero <= 3'b000;
        end else begin
            hold_zero <= next_hold_zero;
        end
    end

    assign live_flag = raw_flag & ~hold_zero;

    // ==========================================================
    // Waiting-for-midamble flag
    logic wait_mid;
    logic next_wait_mid;
    logic chan_rise;
    logic chan_last;
    logic lock_lost;
    logic mid_rise;

    assign chan_rise = qst_rise(live_flag[2], chan_last);
    assign mid_rise  = qst_rise(pin_sync[QST_IN_MID], pin_last[QST_IN_MID]);
    assign lock_lost = (sync_src != QST_SRC_BCH) && qst_fall(sel_sync_ok, sel_sync_ok_last);

    // Set beats both clears when they meet in one cycle
    always_comb begin
        next_wait_mid = wait_mid;
        if (reset_cmd || mid_rise) begin
            next_wait_mid = 1'b0;
        end
        if (chan_rise || lock_lost) begin
            next_wait_mid = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wait_mid  <= 1'b0;
            chan_last <= 1'b0;
        end else begin
            wait_mid  <= next_wait_mid;
            chan_last <= live_flag[2];
        end
    end

    // ==========================================================
    // Condition vectors; unused bits are tied low
    logic [15:0] test_cond;
    logic [15:0] cal_cond;

    always_comb begin
        test_cond                    = QST_ZERO;
        test_cond[QST_BIT_NO_CLK]    = no_clk;
        test_cond[QST_BIT_NO_DATA]   = no_data;
        test_cond[QST_BIT_PRBS]      = live_flag[0];
        test_cond[QST_BIT_UNLOCK]    = pin_sync[QST_IN_DEMOD] | pin_sync[QST_IN_DCONV];
        test_cond[QST_BIT_AMP]       = live_flag[1];
        test_cond[QST_BIT_CHAN_SYNC] = live_flag[2];
        test_cond[QST_BIT_WAIT_MID]  = wait_mid;
        cal_cond                     = QST_ZERO;
        cal_cond[QST_CAL_BIT_IQ]     = pin_sync[QST_IN_IQ];
        cal_cond[QST_CAL_BIT_DCZ]    = pin_sync[QST_IN_DCZ];
    end

    // ==========================================================
    // Subgroups
    logic        wr_cmd;
    logic        rd_cmd;
    logic [15:0] cal_ptr;
    logic [15:0] cal_ntr;
    logic [15:0] cal_enable;
    logic [15:0] cal_event;
    logic [15:0] tst_ptr;
    logic [15:0] tst_ntr;
    logic [15:0] tst_enable;
    logic [15:0] tst_event;

    assign wr_cmd = reg_valid & reg_write;
    assign rd_cmd = reg_valid & ~reg_write;

    // Values arrive as plain binary weights; the command parser sums them
    qst_subgroup u_cal (
        .clk        (clk),
        .rst        (rst),
        .cond       (cal_cond),
        .wdata      (reg_wdata),
        .wr_ptr     (wr_cmd && reg_sel == QST_SEL_CAL_PTR),
        .wr_ntr     (wr_cmd && reg_sel == QST_SEL_CAL_NTR),
        .wr_enable  (wr_cmd && reg_sel == QST_SEL_CAL_ENABLE),
        .rd_event   (rd_cmd && reg_sel == QST_SEL_CAL_EVENT),
        .ptr        (cal_ptr),
        .ntr        (cal_ntr),
        .enable     (cal_enable),
        .event_bits (cal_event),
        .summary    (cal_summary)
    );

    qst_subgroup u_tst (
        .clk        (clk),
        .rst        (rst),
        .cond       (test_cond),
        .wdata      (reg_wdata),
        .wr_ptr     (wr_cmd && reg_sel == QST_SEL_TST_PTR),
        .wr_ntr     (wr_cmd && reg_sel == QST_SEL_TST_NTR),
        .wr_enable  (wr_cmd && reg_sel == QST_SEL_TST_ENABLE),
        .rd_event   (rd_cmd && reg_sel == QST_SEL_TST_EVENT),
        .ptr        (tst_ptr),
        .ntr        (tst_ntr),
        .enable     (tst_enable),
        .event_bits (tst_event),
        .summary    (test_summary)
    );

    // ==========================================================
    // Query answers
    // Condition writes fall through with no effect, keeping them read-only.
    logic [15:0] next_rdata;
    logic        next_ack;

    always_comb begin
        next_ack   = reg_valid;
        next_rdata = reg_rdata;
        if (rd_cmd) begin
            unique case (reg_sel)
                QST_SEL_CAL_COND:   next_rdata = cal_cond;
                QST_SEL_CAL_PTR:    next_rdata = cal_ptr;
                QST_SEL_CAL_NTR:    next_rdata = cal_ntr;
                QST_SEL_CAL_EVENT:  next_rdata = cal_event;
                QST_SEL_CAL_ENABLE: next_rdata = cal_enable;
                QST_SEL_TST_COND:   next_rdata = test_cond;
                QST_SEL_TST_PTR:    next_rdata = tst_ptr;
                QST_SEL_TST_NTR:    next_rdata = tst_ntr;
                QST_SEL_TST_EVENT:  next_rdata = tst_event;
                QST_SEL_TST_ENABLE: next_rdata = tst_enable;
                default:            next_rdata = QST_ZERO;  // Unmapped selector
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= QST_ZERO;
            reg_ack   <= 1'b0;
        end else begin
            reg_rdata <= next_rdata;
            reg_ack   <= next_ack;
        end
    end

endmodule : qst_status

// File: qst_pkg.sv
// Constants, types and helpers shared by the questionable status subgroups.
// Assumes a single 40 MHz system clock and 16-bit status registers.
package qst_pkg;

    // ==========================================================
    // Widths and clocking
    localparam int unsigned QST_W              = 16;
    localparam int unsigned QST_CLK_HZ         = 40_000_000;
    localparam int unsigned QST_NO_CLK_TIME_MS = 3000;
    localparam int unsigned QST_NO_CLK_CYCLES  = QST_NO_CLK_TIME_MS * (QST_CLK_HZ / 1000);
    localparam int unsigned QST_NO_CLK_CNT_W   = 27;
    localparam int unsigned QST_NO_DATA_EDGES  = 200;
    localparam int unsigned QST_NO_DATA_CNT_W  = 8;

    // ==========================================================
    // Test-link condition bit positions
    localparam int unsigned QST_BIT_NO_CLK    = 0;
    localparam int unsigned QST_BIT_NO_DATA   = 1;
    localparam int unsigned QST_BIT_PRBS      = 2;
    localparam int unsigned QST_BIT_UNLOCK    = 11;
    localparam int unsigned QST_BIT_AMP       = 12;
    localparam int unsigned QST_BIT_CHAN_SYNC = 13;
    localparam int unsigned QST_BIT_WAIT_MID  = 14;

    // Calibration condition bit positions
    localparam int unsigned QST_CAL_BIT_IQ    = 0;
    localparam int unsigned QST_CAL_BIT_DCZ   = 1;

    // Parent questionable condition bits fed by the summaries
    localparam int unsigned QST_PARENT_CAL_BIT    = 8;
    localparam int unsigned QST_PARENT_TEST_BIT_A = 12;
    localparam int unsigned QST_PARENT_TEST_BIT_B = 3;

    // ==========================================================
    // Reset values
    localparam logic [15:0] QST_PTR_RST    = 16'h7FFF;
    localparam logic [15:0] QST_NTR_RST    = 16'h0000;
    localparam logic [15:0] QST_ENABLE_RST = 16'h0000;
    localparam logic [15:0] QST_ZERO       = 16'h0000;

    // ==========================================================
    // Synchronised pin vector positions
    localparam int unsigned QST_IN_TCLK   = 0;
    localparam int unsigned QST_IN_TDATA  = 1;
    localparam int unsigned QST_IN_PRBS   = 2;
    localparam int unsigned QST_IN_DEMOD  = 3;
    localparam int unsigned QST_IN_DCONV  = 4;
    localparam int unsigned QST_IN_AMP    = 5;
    localparam int unsigned QST_IN_BCH    = 6;
    localparam int unsigned QST_IN_TCH    = 7;
    localparam int unsigned QST_IN_PDCH   = 8;
    localparam int unsigned QST_IN_MID    = 9;
    localparam int unsigned QST_IN_IQ     = 10;
    localparam int unsigned QST_IN_DCZ    = 11;
    localparam int unsigned QST_IN_W      = 12;

    // ==========================================================
    // Sync source selection
    typedef enum logic [1:0] {
        QST_SRC_BCH  = 2'b00,
        QST_SRC_TCH  = 2'b01,
        QST_SRC_PDCH = 2'b10
    } qst_sync_src_t;

    // Register selector for queries and commands
    typedef enum logic [3:0] {
        QST_SEL_CAL_COND   = 4'b0000,
        QST_SEL_CAL_PTR    = 4'b0001,
        QST_SEL_CAL_NTR    = 4'b0010,
        QST_SEL_CAL_EVENT  = 4'b0011,
        QST_SEL_CAL_ENABLE = 4'b0100,
        QST_SEL_TST_COND   = 4'b0101,
        QST_SEL_TST_PTR    = 4'b0110,
        QST_SEL_TST_NTR    = 4'b0111,
        QST_SEL_TST_EVENT  = 4'b1000,
        QST_SEL_TST_ENABLE = 4'b1001
    } qst_sel_t;

    // ==========================================================
    // Edge helpers
    function automatic logic qst_rise(input logic cur, input logic prev);
        return cur & ~prev;
    endfunction : qst_rise

    function automatic logic qst_fall(input logic cur, input logic prev);
        return ~cur & prev;
    endfunction : qst_fall

endpackage : qst_pkg

// File: qst_subgroup.sv
// One status subgroup: transition filters, event latch, enable mask, summary.
// Assumes the condition vector is already on the system clock.
`timescale 1ns/10ps
module qst_subgroup
    import qst_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [15:0] cond,
    input  wire logic [15:0] wdata,
    input  wire logic        wr_ptr,
    input  wire logic        wr_ntr,
    input  wire logic        wr_enable,
    input  wire logic        rd_event,
    output logic      [15:0] ptr,
    output logic      [15:0] ntr,
    output logic      [15:0] enable,
    output logic      [15:0] event_bits,
    output logic             summary
);

    logic [15:0] prev_cond;
    logic [15:0] next_ptr;
    logic [15:0] next_ntr;
    logic [15:0] next_enable;
    logic [15:0] next_event;
    logic [15:0] hits;

    // ==========================================================
    // Filters, mask and event latch
    always_comb begin
        next_ptr    = wr_ptr    ? wdata : ptr;
        next_ntr    = wr_ntr    ? wdata : ntr;
        next_enable = wr_enable ? wdata : enable;
        hits = (cond & ~prev_cond & ptr) | (~cond & prev_cond & ntr);
        // Fresh hits survive a clearing read so no event is lost
        next_event = (rd_event ? QST_ZERO : event_bits) | hits;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_cond  <= QST_ZERO;
            ptr        <= QST_PTR_RST;
            ntr        <= QST_NTR_RST;
            enable     <= QST_ENABLE_RST;
            event_bits <= QST_ZERO;
        end else begin
            prev_cond  <= cond;
            ptr        <= next_ptr;
            ntr        <= next_ntr;
            enable     <= next_enable;
            event_bits <= next_event;
        end
    end

    // Summary follows the latched events every cycle
    assign summary = |(event_bits & enable);

endmodule : qst_subgroup

// File: qst_status_asserts.sv
// Port checker for the questionable status block, bound to qst_status.
// Assumes the single clk domain and the block's active-high async rst.
`timescale 1ns/10ps
module qst_status_chk
    import qst_pkg::*;
#(
    parameter int unsigned NO_CLK_CYCLES = QST_NO_CLK_CYCLES
)
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        iq_cal_fail,
    input wire logic        demod_unlock,
    input wire logic        reg_valid,
    input wire logic        reg_write,
    input wire qst_sel_t    reg_sel,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic        reg_ack,
    input wire logic        cal_summary,
    input wire logic        test_summary
);
    // ========
    // Query and command strobes
    logic q_rd;
    logic q_wr;
    assign q_rd = reg_valid & ~reg_write;
    assign q_wr = reg_valid & reg_write;

    default clocking dflt @(posedge clk); endclocking
    default disable iff (rst);

    // ========
    // Handshake and answer register
    chk_ack_follows: assert property (reg_valid |=> reg_ack)
        else $error("access without ack");
    chk_ack_cause: assert property (reg_ack |-> $past(reg_valid))
        else $error("ack without access");
    chk_rdata_hold: assert property (!q_rd |=> $stable(reg_rdata))
        else $error("answer moved without query");
    chk_ptr_readback: assert property (
        q_wr && reg_sel == QST_SEL_TST_PTR ##1 q_rd && reg_sel == QST_SEL_TST_PTR
        |=> reg_rdata == $past(reg_wdata, 2)) else $error("filter readback wrong");

    // ========
    // Condition contents, sampled after the input synchronisers settle
    chk_tst_unused: assert property (
        q_rd && reg_sel == QST_SEL_TST_COND |=> (reg_rdata & 16'h87F8) == 16'h0000)
        else $error("unused test bits set");
    chk_cal_unused: assert property (
        q_rd && reg_sel == QST_SEL_CAL_COND |=> reg_rdata[15:2] == 14'h0000)
        else $error("unused cal bits set");
    chk_cal_live: assert property (
        iq_cal_fail [*5] ##0 (q_rd && reg_sel == QST_SEL_CAL_COND) |=> reg_rdata[0])
        else $error("cal condition not live");
    chk_lock_live: assert property (
        demod_unlock [*5] ##0 (q_rd && reg_sel == QST_SEL_TST_COND) |=> reg_rdata[11])
        else $error("unlock bit not live");

    // ========
    // Summaries drop as soon as the mask is cleared
    chk_cal_mask_off: assert property (
        q_wr && reg_sel == QST_SEL_CAL_ENABLE && reg_wdata == 16'h0000 |=> !cal_summary)
        else $error("cal summary with empty mask");
    chk_tst_mask_off: assert property (
        q_wr && reg_sel == QST_SEL_TST_ENABLE && reg_wdata == 16'h0000 |=> !test_summary)
        else $error("test summary with empty mask");

    // Main scenarios reached
    cov_cal_event: cover property (q_rd && reg_sel == QST_SEL_CAL_EVENT ##1 reg_rdata != 0);
    cov_cal_sum: cover property ($rose(cal_summary));
    cov_tst_sum: cover property ($rose(test_summary));
endmodule : qst_status_chk

bind qst_status qst_status_chk #(.NO_CLK_CYCLES(NO_CLK_CYCLES)) qst_status_chk_i (
    .clk, .rst, .iq_cal_fail, .demod_unlock, .reg_valid, .reg_write,
    .reg_sel, .reg_wdata, .reg_rdata, .reg_ack, .cal_summary, .test_summary
);

// File: qst_tb.sv
// Self-checking bench for qst_status, driven through its register port.
// Assumes a short no-clock limit of 50 cycles so the run stays brief.
`timescale 1ns/10ps
module testbench
    import qst_pkg::*;
;
    logic           clk, rst, reset_cmd, reg_valid, reg_write, reg_ack;
    logic           test_clk_pin = 1'b0, test_data_pin = 1'b0, prbs_unsync, demod_unlock;
    logic           downconv_unlock, demod_amplitude_range_flag, midamble_seen;
    logic           bch_sync_ok, tch_sync_ok, pdch_sync_ok;
    logic           iq_cal_fail, dc_mod_zero_cal_fail, cal_summary, test_summary;
    logic           tclk_run, data_run;
    logic [2:0]     div = 3'h0;
    logic [15:0]    reg_wdata, reg_rdata, rv;
    qst_sync_src_t  sync_src;
    qst_sel_t       reg_sel;
    int             err_count, checks_done;

    qst_status #(.NO_CLK_CYCLES(50)) qst_status_i (
        .clk, .rst, .reset_cmd, .sync_src, .test_clk_pin, .test_data_pin,
        .prbs_unsync, .demod_unlock, .downconv_unlock, .demod_amplitude_range_flag,
        .bch_sync_ok, .tch_sync_ok, .pdch_sync_ok, .midamble_seen, .iq_cal_fail,
        .dc_mod_zero_cal_fail, .reg_valid, .reg_write, .reg_sel, .reg_wdata,
        .reg_rdata, .reg_ack, .cal_summary, .test_summary
    );

    // ========
    // Clock, 25 ns period
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Test link pins: clock period of 8 cycles, data toggling once a period
    always @(negedge clk) begin
        div <= div + 3'h1;
        if (tclk_run && div[1:0] == 2'h0) test_clk_pin <= ~test_clk_pin;
        if (data_run && div == 3'h0) test_data_pin <= ~test_data_pin;
    end

    // ========
    // Compare, count, report
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : chk

    // One access: strobe for one cycle, answer one cycle later
    task automatic acc(input logic wr, input qst_sel_t sel, input logic [15:0] wd);
        @(negedge clk);
        reg_valid = 1'b1;
        reg_write = wr;
        reg_sel   = sel;
        reg_wdata = wd;
        @(negedge clk);
        reg_valid = 1'b0;
        chk("ack", {15'h0000, reg_ack}, 16'h0001);
        rv = reg_rdata;
    endtask : acc

    task automatic rdc(input qst_sel_t s, input logic [15:0] m, e, input string name);
        acc(1'b0, s, 16'h0000);
        chk(name, rv & m, e);
    endtask : rdc

    task automatic rcmd();
        @(negedge clk) reset_cmd = 1'b1;
        @(negedge clk) reset_cmd = 1'b0;
        repeat (4) @(negedge clk);
    endtask : rcmd

    task automatic conclude();
        $display("checks %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : conclude

    // Hang guard, well beyond the roughly 2200 cycles of the sequence
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        conclude();
    end

    // ========
    // Main sequence
    initial begin
        {rst, tclk_run, data_run, bch_sync_ok} = 4'hF;
        {reset_cmd, reg_valid, reg_write} = 3'h0;
        {prbs_unsync, demod_unlock, downconv_unlock, demod_amplitude_range_flag} = 4'h0;
        {tch_sync_ok, pdch_sync_ok, midamble_seen, iq_cal_fail, dc_mod_zero_cal_fail} = 5'h00;
        {reg_wdata, err_count, checks_done} = '0;
        reg_sel  = QST_SEL_CAL_COND;
        sync_src = QST_SRC_BCH;
        repeat (10) @(posedge clk);
        @(negedge clk) rst = 1'b0;

        // Reset contents and the unmapped selector
        for (int g = 0; g < 2; g++) begin
            rdc(qst_sel_t'(4'(5 * g + 1)), 16'hFFFF, QST_PTR_RST, "ptr");
            rdc(qst_sel_t'(4'(5 * g + 2)), 16'hFFFF, QST_NTR_RST, "ntr");
            rdc(qst_sel_t'(4'(5 * g + 4)), 16'hFFFF, QST_ENABLE_RST, "enable");
        end
        rdc(QST_SEL_CAL_EVENT, 16'hFFFF, 16'h0000, "cal event");
        rdc(qst_sel_t'(4'hF), 16'hFFFF, 16'h0000, "unmapped");
        $display("test reset done");

        // Filters and masks as weighted sums; condition refuses writes
        acc(1'b1, QST_SEL_CAL_PTR, 16'h0001);
        acc(1'b1, QST_SEL_CAL_NTR, 16'h0002);
        acc(1'b1, QST_SEL_CAL_ENABLE, 16'h0000);
        acc(1'b1, QST_SEL_CAL_COND, 16'hFFFF);
        rdc(QST_SEL_CAL_COND, 16'hFFFF, 16'h0000, "cal cond");
        rdc(QST_SEL_CAL_NTR, 16'hFFFF, 16'h0002, "cal ntr");
        rdc(QST_SEL_CAL_NTR, 16'hFFFF, 16'h0002, "cal ntr again");
        // Write then read on consecutive edges
        @(negedge clk);
        {reg_valid, reg_write, reg_wdata} = {2'b11, 16'h0800};
        reg_sel = QST_SEL_TST_PTR;
        @(negedge clk) reg_write = 1'b0;
        @(negedge clk) reg_valid = 1'b0;
        @(negedge clk) chk("ptr b2b", reg_rdata, 16'h0800);
        $display("test access done");

        // Calibration events: rise of bit 0, fall of bit 1 only
        iq_cal_fail = 1'b1;
        repeat (6) @(negedge clk);
        rdc(QST_SEL_CAL_COND, 16'hFFFF, 16'h0001, "iq cond");
        iq_cal_fail = 1'b0;
        repeat (6) @(negedge clk);
        rdc(QST_SEL_CAL_EVENT, 16'hFFFF, 16'h0001, "iq event");
        dc_mod_zero_cal_fail = 1'b1;
        repeat (6) @(negedge clk);
        rdc(QST_SEL_CAL_COND, 16'hFFFF, 16'h0002, "dc cond");
        dc_mod_zero_cal_fail = 1'b0;
        repeat (6) @(negedge clk);
        chk("cal sum off", {15'h0000, cal_summary}, 16'h0000);
        acc(1'b1, QST_SEL_CAL_ENABLE, 16'h0002);
        chk("cal sum on", {15'h0000, cal_summary}, 16'h0001);
        rdc(QST_SEL_CAL_EVENT, 16'hFFFF, 16'h0002, "dc event");
        chk("cal sum clr", {15'h0000, cal_summary}, 16'h0000);
        rdc(QST_SEL_CAL_EVENT, 16'hFFFF, 16'h0000, "event clr");
        $display("test calibration done");

        // Test-link status bits and the reset command
        rcmd();
        rdc(QST_SEL_TST_COND, 16'h7FFF, 16'h0000, "idle");
        prbs_unsync = 1'b1;
        repeat (6) @(negedge clk);
        rdc(QST_SEL_TST_COND, 16'h1804, 16'h0004, "prbs");
        demod_unlock = 1'b1;
        repeat (6) @(negedge clk);
        rdc(QST_SEL_TST_COND, 16'h1804, 16'h0804, "demod");
        {demod_unlock, downconv_unlock, demod_amplitude_range_flag} = 3'b011;
        repeat (6) @(negedge clk);
        rdc(QST_SEL_TST_COND, 16'h1804, 16'h1804, "conv amp");
        rcmd();
        rdc(QST_SEL_TST_COND, 16'h1804, 16'h0800, "cmd clr");
        {prbs_unsync, downconv_unlock, demod_amplitude_range_flag} = 3'b000;
        repeat (6) @(negedge clk);
        rdc(QST_SEL_TST_COND, 16'h1804, 16'h0000, "cleared");
        $display("test condition done");

        // Each sync source: only the selected channel counts; code 11 acts as BCH
        for (int s = 0; s < 4; s++) begin
            sync_src = qst_sync_src_t'(2'(s));
            {pdch_sync_ok, tch_sync_ok, bch_sync_ok} = 3'(1 << (s % 3));
            rcmd();
            rdc(QST_SEL_TST_COND, 16'h6000, 16'h0000, "synced");
            {pdch_sync_ok, tch_sync_ok, bch_sync_ok} = 3'b000;
            repeat (6) @(negedge clk);
            rdc(QST_SEL_TST_COND, 16'h6000, 16'h6000, "lost");
            rcmd();
            rdc(QST_SEL_TST_COND, 16'h6000, 16'h0000, "lost clr");
            {pdch_sync_ok, tch_sync_ok, bch_sync_ok} = 3'(1 << (s % 3));
            repeat (6) @(negedge clk);
            {pdch_sync_ok, tch_sync_ok, bch_sync_ok} = 3'b000;
            repeat (6) @(negedge clk);
            {pdch_sync_ok, tch_sync_ok, bch_sync_ok} = 3'(1 << (s % 3));
            repeat (6) @(negedge clk);
            rdc(QST_SEL_TST_COND, 16'h6000, 16'h4000, "waiting");
            midamble_seen = 1'b1;
            repeat (4) @(negedge clk);
            midamble_seen = 1'b0;
            repeat (4) @(negedge clk);
            rdc(QST_SEL_TST_COND, 16'h6000, 16'h0000, "midamble");
        end
        sync_src = QST_SRC_BCH;
        {pdch_sync_ok, tch_sync_ok, bch_sync_ok} = 3'b001;
        $display("test sync done");

        // Test-link events and summary through the bit 11 mask
        acc(1'b1, QST_SEL_TST_ENABLE, 16'h0800);
        acc(1'b0, QST_SEL_TST_EVENT, 16'h0000);
        chk("tst sum off", {15'h0000, test_summary}, 16'h0000);
        demod_unlock = 1'b1;
        repeat (6) @(negedge clk);
        chk("tst sum on", {15'h0000, test_summary}, 16'h0001);
        rdc(QST_SEL_TST_EVENT, 16'h0800, 16'h0800, "tst event");
        chk("tst sum clr", {15'h0000, test_summary}, 16'h0000);
        demod_unlock = 1'b0;
        repeat (6) @(negedge clk);
        rdc(QST_SEL_TST_EVENT, 16'hFFFF, 16'h0000, "no fall");
        acc(1'b1, QST_SEL_TST_ENABLE, 16'h0000);
        $display("test summary done");

        // Lost test clock, then static data for 200 test clocks
        tclk_run = 1'b0;
        repeat (35) @(negedge clk);
        rdc(QST_SEL_TST_COND, 16'h0001, 16'h0000, "clk short");
        repeat (20) @(negedge clk);
        rdc(QST_SEL_TST_COND, 16'h0001, 16'h0001, "clk gone");
        tclk_run = 1'b1;
        repeat (20) @(negedge clk);
        rdc(QST_SEL_TST_COND, 16'h0001, 16'h0000, "clk back");
        data_run = 1'b0;
        repeat (190 * 8) @(negedge clk);
        rdc(QST_SEL_TST_COND, 16'h0002, 16'h0000, "data 190");
        repeat (20 * 8) @(negedge clk);
        rdc(QST_SEL_TST_COND, 16'h0002, 16'h0002, "data 210");
        data_run = 1'b1;
        repeat (40) @(negedge clk);
        rdc(QST_SEL_TST_COND, 16'h0002, 16'h0000, "data back");
        $display("test timing done");
        conclude();
    end
endmodule : testbench
